// file: pkg/acs_pkg.sv
// Constants and types of the conversion sequencer
// ------------------------------------------------------------
// How it works
// - Clock choice bit set means the bus clock drives conversions.
// - Bus-clocked: tracking starts on seventh falling clock edge of address byte.
// - Bus-clocked: one bus clock later the sample is held and converted.
// - Bus-clocked: data shifts out right after the address acknowledge, no stretching.
// - Bus-clocked: conversions continue byte after byte until master not-acknowledges.
// - Written byte bit 7: one is setup byte, zero is configuration byte.
// - Configuration bits 6 and 5 pick the scan pattern; reset zero.
// - Configuration bits 4 to 1 pick the channel; reset 0000.
// - Smaller variants force unused upper channel bits to zero.
// - Configuration bit 0: one single-ended, zero pseudo-differential; reset one.
// - Shared pin used as reference is skipped in multichannel scans.
// - Power-up: single-ended channel zero, oscillator, supply reference, shared pin input.
// - Result memory is undefined after power-up until conversions fill it.
// - Reference select 100 powers analog down whenever idle.
// - Oscillator mode with auto power-down sleeps once all results are stored.
// - Results survive power-down and stay readable until STOP or repeated START.
// - Bus-clocked: idle device wakes on its own valid address with no delay; oscillator mode wakes when conversions start.
// - Shared pin in reference use converts as ground.
// - Clock choice bit zero selects oscillator, one bus clock; oscillator at power-up.
// - On master not-acknowledge during read, release the data line.
// - Single-ended codes 0000 to 1011 pick inputs; 1100 to 1111 reserved.
// ------------------------------------------------------------
package acs_pkg;
    localparam int CHANNELS = 12;
    localparam logic [3:0] CHAN_MASK = (CHANNELS == 4) ? 4'h3 : (CHANNELS == 8) ? 4'h7 : 4'hF;
    localparam logic [3:0] SHARED_CH = 4'(CHANNELS - 1);
    localparam logic HAS_SHARED = (CHANNELS != 8);
    localparam logic [3:0] TOP_CH = 4'(CHANNELS - 1);
    localparam logic [3:0] CHAN_RESERVED = 4'hC;
    localparam logic [6:0] SLAVE_ADDR = 7'h65;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [7:0] EMPTY_BYTE = 8'hFF;
    localparam int KIND_BIT = 7;
    localparam int SCAN_HI = 6;
    localparam int SCAN_LO = 5;
    localparam int CHAN_HI = 4;
    localparam int CHAN_LO = 1;
    localparam int SGL_BIT = 0;
    localparam int SEL_HI = 6;
    localparam int SEL_LO = 4;
    localparam int CLK_BIT = 3;
    localparam logic [1:0] SCAN_RST = 2'h0;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic SGL_RST = 1'b1;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic CLK_RST = 1'b0;
    localparam logic [2:0] SEL_AUTO_OFF = 3'h4;
    localparam logic [1:0] SCAN_ONLY = 2'h0;
    localparam logic [1:0] SCAN_UPTO = 2'h1;
    localparam logic [1:0] SCAN_FROM = 2'h2;
    localparam int CLK_MHZ = 50;
    localparam int INT_CONV_NS = 7600;
    localparam int CNT_W = 9;
    localparam int INT_CONV_CYC = (INT_CONV_NS * CLK_MHZ) / 1000;
    localparam int INT_ACQ_CYC = 2;
    typedef enum logic [2:0] {
        B_IDLE, B_ADDR, B_ADDR_ACK, B_WRITE, B_STRETCH, B_READ, B_DONE, B_IGNORE
    } acs_bus_e;
endpackage

// file: hw/acs_sequencer.sv
// Result FIFO and conversion sequencer with its two-wire slave
`timescale 1ns/1ps

// ------------------------------------------------------------
// Result FIFO
// ------------------------------------------------------------
module acs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [AW:0] next_wp;
    logic [AW:0] next_rp;
    logic do_push;
    logic do_pop;

    assign in_ready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    assign out_valid = (wp != rp);
    assign out_data = mem[rp[AW-1:0]];
    assign do_push = in_valid && in_ready && !flush;
    assign do_pop = out_valid && out_ready && !flush;

    always_comb begin
        next_wp = wp;
        next_rp = rp;
        if (flush) begin
            next_wp = '0;
            next_rp = '0;
        end else begin
            if (do_push) begin
                next_wp = wp + 1'b1;
            end
            if (do_pop) begin
                next_rp = rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp <= '0;
            rp <= '0;
        end else if (ce) begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    // Storage has no reset
    always_ff @(posedge clk) begin
        if (ce && do_push) begin
            mem[wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// ------------------------------------------------------------
// Sequencer top
// ------------------------------------------------------------
module acs_sequencer (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Two-wire bus pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Analog core
    input wire logic [acs_pkg::DATA_W-1:0] adc_result,
    output logic adc_track,
    output logic adc_convert,
    output logic [3:0] adc_channel,
    output logic adc_ground,
    output logic adc_single_ended,
    output logic adc_bus_clocked,
    output logic adc_powered
);
    import acs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and bus events
    // ------------------------------------------------------------
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce) begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
        end
    end

    assign scl_rise = scl_sy[1] && !scl_d;
    assign scl_fall = !scl_sy[1] && scl_d;
    assign bus_start = scl_sy[1] && scl_d && !sda_sy[1] && sda_d;
    assign bus_stop = scl_sy[1] && scl_d && sda_sy[1] && !sda_d;

    // ------------------------------------------------------------
    // Shared declarations
    // ------------------------------------------------------------
    acs_bus_e st;
    acs_bus_e next_st;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] rx;
    logic [7:0] next_rx;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic rd;
    logic next_rd;
    logic mack;
    logic next_mack;
    logic next_sda_oe;
    logic [1:0] cfg_scan;
    logic [1:0] next_scan;
    logic [3:0] cfg_chan;
    logic [3:0] next_chan;
    logic cfg_sgl;
    logic next_sgl;
    logic [2:0] set_sel;
    logic [2:0] next_sel;
    logic set_clk;
    logic next_clk;
    logic ext_track;
    logic ext_conv;
    logic int_go;
    logic pop;
    logic flush;
    logic push;
    logic int_release;
    logic f_in_ready;
    logic f_out_valid;
    logic [7:0] f_out_data;
    logic [7:0] load_byte;
    logic [3:0] first_ch;
    logic [3:0] last_ch;
    logic skip_shared;
    logic [3:0] scan_top;

    assign load_byte = f_out_valid ? f_out_data : EMPTY_BYTE;
    assign first_ch = (cfg_scan == SCAN_UPTO) ? 4'h0 : cfg_chan;
    assign scan_top = (cfg_scan == SCAN_FROM) ? TOP_CH : cfg_chan;
    assign skip_shared = (cfg_scan != SCAN_ONLY) && set_sel[1] && HAS_SHARED;
    // A skipped shared pin must not be the end of the scan
    assign last_ch = (skip_shared && scan_top == SHARED_CH) ? SHARED_CH - 4'h1 : scan_top;

    // ------------------------------------------------------------
    // Bus slave and configuration
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_bit_cnt = bit_cnt;
        next_rx = rx;
        next_tx = tx;
        next_rd = rd;
        next_mack = mack;
        next_sda_oe = sda_oe;
        next_scan = cfg_scan;
        next_chan = cfg_chan;
        next_sgl = cfg_sgl;
        next_sel = set_sel;
        next_clk = set_clk;
        ext_track = 1'b0;
        ext_conv = 1'b0;
        int_go = 1'b0;
        pop = 1'b0;
        flush = 1'b0;
        if (bus_start) begin
            next_st = B_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
            flush = 1'b1;
        end else if (bus_stop) begin
            next_st = B_IDLE;
            next_sda_oe = 1'b0;
            flush = 1'b1;
        end else if (st == B_STRETCH) begin
            if (int_release) begin
                pop = 1'b1;
                next_tx = load_byte;
                next_sda_oe = !load_byte[7];
                next_st = B_READ;
            end
        end else if (scl_rise && st != B_IDLE) begin
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt < 4'h8) begin
                next_rx = {rx[6:0], sda_sy[1]};
            end else begin
                next_mack = sda_sy[1];
            end
        end else if (scl_fall && st != B_IDLE && bit_cnt != 4'h0) begin
            if (bit_cnt == 4'h9) begin
                next_bit_cnt = 4'h0;
            end
            case (st)
                B_ADDR: begin
                    if (bit_cnt == 4'h7 && set_clk && rx[6:0] == SLAVE_ADDR) begin
                        ext_track = 1'b1;
                    end
                    if (bit_cnt == 4'h8) begin
                        if (rx[7:1] == SLAVE_ADDR) begin
                            next_st = B_ADDR_ACK;
                            next_sda_oe = 1'b1;
                            next_rd = rx[0];
                            ext_conv = set_clk && rx[0];
                        end else begin
                            next_st = B_IGNORE;
                        end
                    end
                end
                B_ADDR_ACK: begin
                    if (bit_cnt == 4'h9) begin
                        if (!rd) begin
                            next_st = B_WRITE;
                            next_sda_oe = 1'b0;
                        end else if (set_clk) begin
                            pop = 1'b1;
                            next_tx = load_byte;
                            next_sda_oe = !load_byte[7];
                            next_st = B_READ;
                        end else begin
                            int_go = 1'b1;
                            next_sda_oe = 1'b0;
                            next_st = B_STRETCH;
                        end
                    end
                end
                B_WRITE: begin
                    if (bit_cnt == 4'h8) begin
                        next_sda_oe = 1'b1;
                        if (rx[KIND_BIT]) begin
                            next_sel = rx[SEL_HI:SEL_LO];
                            next_clk = rx[CLK_BIT];
                        end else begin
                            next_scan = rx[SCAN_HI:SCAN_LO];
                            next_chan = rx[CHAN_HI:CHAN_LO] & CHAN_MASK;
                            next_sgl = rx[SGL_BIT];
                        end
                    end else if (bit_cnt == 4'h9) begin
                        next_sda_oe = 1'b0;
                    end
                end
                B_READ: begin
                    if (bit_cnt < 4'h8) begin
                        next_tx = {tx[6:0], 1'b0};
                        next_sda_oe = !tx[6];
                        ext_track = set_clk && bit_cnt == 4'h7;
                    end else if (bit_cnt == 4'h8) begin
                        next_sda_oe = 1'b0;
                        ext_conv = set_clk;
                    end else if (!mack && !f_out_valid && !int_release) begin
                        // Buffer drained while conversions still run: stretch again
                        next_st = B_STRETCH;
                    end else if (!mack) begin
                        pop = 1'b1;
                        next_tx = load_byte;
                        next_sda_oe = !load_byte[7];
                    end else begin
                        next_st = B_DONE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= B_IDLE;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            rd <= 1'b0;
            mack <= 1'b1;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            cfg_scan <= SCAN_RST;
            cfg_chan <= CHAN_RST;
            cfg_sgl <= SGL_RST;
            set_sel <= SEL_RST;
            set_clk <= CLK_RST;
        end else if (ce) begin
            st <= next_st;
            bit_cnt <= next_bit_cnt;
            rx <= next_rx;
            tx <= next_tx;
            rd <= next_rd;
            mack <= next_mack;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            // Clock stays held one cycle past the data load for setup
            scl_oe <= (next_st == B_STRETCH) || (st == B_STRETCH);
            cfg_scan <= next_scan;
            cfg_chan <= next_chan;
            cfg_sgl <= next_sgl;
            set_sel <= next_sel;
            set_clk <= next_clk;
        end
    end

    assign adc_single_ended = cfg_sgl;
    assign adc_bus_clocked = set_clk;

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    logic [3:0] cur;
    logic [3:0] next_cur;
    logic busy;
    logic next_busy;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_track;
    logic next_conv;
    logic next_ground;
    logic next_pow;
    logic [3:0] next_show;
    logic awake;

    function automatic logic [3:0] step_ch(input logic [3:0] c, input logic [3:0] lo,
                                           input logic [3:0] hi, input logic skip);
        logic [3:0] n;
        n = (c >= hi) ? lo : c + 4'h1;
        if (skip && n == SHARED_CH) begin
            n = (n >= hi) ? lo : n + 4'h1;
        end
        return n;
    endfunction

    assign int_release = !busy || !f_in_ready;
    assign awake = (next_st != B_IDLE) && (next_st != B_ADDR) && (next_st != B_IGNORE);

    always_comb begin
        next_cur = cur;
        next_busy = busy;
        next_cnt = cnt;
        next_track = 1'b0;
        next_conv = 1'b0;
        push = 1'b0;
        if (int_go) begin
            next_cur = first_ch;
            next_busy = 1'b1;
            next_cnt = '0;
            next_track = 1'b1;
        end else if (busy) begin
            if (cnt != CNT_W'(INT_CONV_CYC)) begin
                next_cnt = cnt + 1'b1;
            end
            if (cnt == CNT_W'(INT_ACQ_CYC)) begin
                next_conv = 1'b1;
                push = 1'b1;
            end
            if (cnt == CNT_W'(INT_CONV_CYC)) begin
                if (cur == last_ch) begin
                    next_busy = 1'b0;
                end else if (f_in_ready) begin
                    next_cur = step_ch(cur, first_ch, last_ch, skip_shared);
                    next_cnt = '0;
                    next_track = 1'b1;
                end
            end
        end else if (ext_track) begin
            next_track = 1'b1;
        end else if (ext_conv) begin
            next_conv = 1'b1;
            push = 1'b1;
            next_cur = step_ch(cur, first_ch, last_ch, skip_shared);
        end else if (flush) begin
            next_cur = first_ch;
        end
        // Convert pulse shows the channel held, not the one stepped to
        next_show = next_conv ? cur : next_cur;
        next_ground = (next_show >= CHAN_RESERVED)
            || (set_sel[1] && HAS_SHARED && next_show == SHARED_CH);
        next_pow = (set_sel != SEL_AUTO_OFF) || next_busy || (set_clk && awake);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= 4'h0;
            busy <= 1'b0;
            cnt <= '0;
            adc_track <= 1'b0;
            adc_convert <= 1'b0;
            adc_channel <= 4'h0;
            adc_ground <= 1'b0;
            adc_powered <= 1'b1;
        end else if (ce) begin
            cur <= next_cur;
            busy <= next_busy;
            cnt <= next_cnt;
            adc_track <= next_track;
            adc_convert <= next_conv;
            adc_channel <= next_show;
            adc_ground <= next_ground;
            adc_powered <= next_pow;
        end
    end

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    acs_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .flush(flush),
        .in_valid(push),
        .in_ready(f_in_ready),
        .in_data(adc_result),
        .out_valid(f_out_valid),
        .out_ready(pop),
        .out_data(f_out_data)
    );
endmodule

// file: sim/acs_sequencer_monitor.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
module acs_sequencer_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    // Analog core
    input wire logic adc_track,
    input wire logic adc_convert,
    input wire logic [3:0] adc_channel,
    input wire logic adc_ground,
    input wire logic adc_single_ended,
    input wire logic adc_bus_clocked,
    input wire logic adc_powered
);
    import acs_pkg::*;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [3:0] fall_n;
    logic [3:0] next_fall_n;
    logic stop_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // -----------------------------
    // Bus clock fall counter
    // -----------------------------
    assign stop_seen = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
    always_comb begin
        next_fall_n = fall_n;
        if (scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1]) begin
            next_fall_n = 4'hF;
        end else if (scl_s[2] && !scl_s[1]) begin
            next_fall_n = (fall_n == 4'hF) ? 4'h0 : (fall_n == 4'h9) ? 4'h1 : fall_n + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            fall_n <= 4'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            fall_n <= next_fall_n;
        end
    end
    // -----------------------------
    // Assertions
    // -----------------------------
    AST_TRACK_FALL7: assert property (adc_track && adc_bus_clocked |-> fall_n == 4'h7)
        else $error("track pulse away from seventh clock fall");
    AST_TRACK_PULSE: assert property (adc_track |=> !adc_track)
        else $error("track pulse longer than one cycle");
    AST_CONV_FALL8: assert property (adc_convert && adc_bus_clocked |-> fall_n == 4'h8)
        else $error("conversion not one bus clock after tracking");
    AST_NO_STRETCH: assert property (adc_bus_clocked && $past(adc_bus_clocked) |-> !scl_oe)
        else $error("bus clock stretched in bus-clocked mode");
    AST_RESERVED_GND: assert property (adc_convert && adc_channel >= CHAN_RESERVED |-> adc_ground)
        else $error("reserved channel code not converted as ground");
    AST_INPUT_NOT_GND: assert property (adc_convert && adc_channel < SHARED_CH |-> !adc_ground)
        else $error("plain input converted as ground");
    AST_POWER_CONV: assert property (adc_convert |-> adc_powered)
        else $error("conversion while powered down");
    AST_RESET_DEFAULT: assert property ($rose(rst_b) |-> adc_single_ended && !adc_bus_clocked && adc_powered)
        else $error("wrong defaults after reset");
    AST_STOP_RELEASE: assert property (stop_seen |-> ##[1:6] !sda_oe)
        else $error("data line held after stop");
endmodule

bind acs_sequencer acs_sequencer_monitor mon_u (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .adc_track(adc_track), .adc_convert(adc_convert),
    .adc_channel(adc_channel), .adc_ground(adc_ground), .adc_single_ended(adc_single_ended),
    .adc_bus_clocked(adc_bus_clocked), .adc_powered(adc_powered));

// file: sim/acs_bus_master.sv
// Two-wire bus master model
`timescale 1ns/1ps
module acs_bus_master (
    // Clock
    input wire logic clk,
    // Bus wires, pulled up
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull,
    // Status
    output logic hang
);
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        hang = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Release clock and wait out stretching
    task automatic rise();
        int i;
        i = 0;
        scl_pull <= 1'b0;
        tick(1);
        while (scl !== 1'b1 && i < 5000) begin
            tick(1);
            i++;
        end
        if (i >= 5000) hang <= 1'b1;
    endtask
    // One bit, 7 clocks: data set in low phase
    task automatic bit_io(input logic b, output logic r);
        tick(3);
        sda_pull <= ~b;
        tick(2);
        rise();
        r = sda;
        tick(1);
        scl_pull <= 1'b1;
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        tick(2);
        rise();
        tick(3);
        sda_pull <= 1'b1;
        tick(4);
        scl_pull <= 1'b1;
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        tick(3);
        rise();
        tick(3);
        sda_pull <= 1'b0;
        tick(4);
    endtask
    // Byte MSB first, then acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic nack, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(nack, ack);
    endtask
endmodule

// file: sim/acs_sequencer_test.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_test;
    import acs_pkg::*;
    logic clk;
    logic rst_b;
    logic scl;
    logic sda;
    logic scl_oe;
    logic sda_oe;
    logic m_scl;
    logic m_sda;
    logic hang;
    logic [7:0] adc_result;
    logic adc_convert;
    logic [3:0] adc_channel;
    logic adc_ground;
    logic adc_single_ended;
    logic adc_bus_clocked;
    logic adc_powered;
    logic [7:0] set_t [6] = '{8'h88, 8'h88, 8'hA8, 8'hC8, 8'hC0, 8'hA0};
    logic [7:0] cfg_t [6] = '{8'h06, 8'h19, 8'h17, 8'h55, 8'h01, 8'h37};
    int nb_t [6] = '{3, 1, 1, 2, 1, 11};
    logic [3:0] ch_t [6] = '{4'h3, 4'hC, 4'hB, 4'hA, 4'h0, 4'hA};
    int err_total = 0;
    int comparisons = 0;
    int conv_n = 0;
    logic last_gnd;
    logic last_pwr;
    logic [3:0] last_ch;
    assign scl = !(scl_oe | m_scl);
    assign sda = !(sda_oe | m_sda);
    always #10 clk = ~clk;
    acs_sequencer dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .adc_result(adc_result), .adc_track(),
        .adc_convert(adc_convert), .adc_channel(adc_channel), .adc_ground(adc_ground),
        .adc_single_ended(adc_single_ended), .adc_bus_clocked(adc_bus_clocked), .adc_powered(adc_powered));
    acs_bus_master mst_u (.clk(clk), .scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda), .hang(hang));
    // -----------------------------
    // Analog core: new value per conversion
    // -----------------------------
    always @(posedge clk) begin
        if (adc_convert) begin
            adc_result <= adc_result + 8'h1;
            conv_n++;
            last_gnd = adc_ground;
            last_pwr = adc_powered;
            last_ch = adc_channel;
        end
    end
    always @(posedge hang) begin
        err_total++;
        stop_test();
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] b0, input logic [7:0] b1);
        logic [7:0] q;
        logic a;
        mst_u.start();
        mst_u.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, a);
        check("write address ack", 8'(a), 8'h0);
        mst_u.xfer(b0, 1'b1, q, a);
        check("setup byte ack", 8'(a), 8'h0);
        mst_u.xfer(b1, 1'b1, q, a);
        check("config byte ack", 8'(a), 8'h0);
        mst_u.stop();
    endtask
    task automatic rd(input int n);
        logic [7:0] q;
        logic [7:0] base;
        logic a;
        base = adc_result;
        mst_u.start();
        mst_u.xfer({SLAVE_ADDR, 1'b1}, 1'b1, q, a);
        check("read address ack", 8'(a), 8'h0);
        for (int k = 0; k < n; k++) begin
            mst_u.xfer(8'hFF, k == n - 1, q, a);
            check("result byte", q, base + 8'(k));
        end
    endtask
    // -----------------------------
    // Main sequence
    // -----------------------------
    initial begin
        logic [7:0] q;
        logic a;
        logic exp_g;
        clk = 1'b0;
        rst_b = 1'b0;
        adc_result = 8'h40;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        check("single-ended at reset", 8'(adc_single_ended), 8'h1);
        check("bus clock at reset", 8'(adc_bus_clocked), 8'h0);
        check("power at reset", 8'(adc_powered), 8'h1);
        mst_u.start();
        mst_u.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
        check("foreign address ack", 8'(a), 8'h1);
        mst_u.stop();
        $display("reset and address test done");
        for (int r = 0; r < 6; r++) begin
            exp_g = (ch_t[r] >= CHAN_RESERVED) || (ch_t[r] == SHARED_CH && set_t[r][SEL_LO + 1]);
            wr(set_t[r], cfg_t[r]);
            check("clock choice", 8'(adc_bus_clocked), 8'(set_t[r][CLK_BIT]));
            check("input mode", 8'(adc_single_ended), 8'(cfg_t[r][SGL_BIT]));
            conv_n = 0;
            rd(nb_t[r]);
            mst_u.tick(4);
            check("data released", 8'(sda_oe), 8'h0);
            check("channel", 8'(last_ch), 8'(ch_t[r]));
            check("ground", 8'(last_gnd), 8'(exp_g));
            check("power at conversion", 8'(last_pwr), 8'h1);
            check("power before stop", 8'(adc_powered),
                8'(set_t[r][CLK_BIT] || set_t[r][SEL_HI:SEL_LO] != SEL_AUTO_OFF));
            if (!set_t[r][CLK_BIT]) check("conversions", 8'(conv_n), 8'(nb_t[r]));
            mst_u.stop();
            mst_u.tick(8);
            check("power when idle", 8'(adc_powered), 8'(set_t[r][SEL_HI:SEL_LO] != SEL_AUTO_OFF));
            $display("row %0d done", r);
        end
        stop_test();
    end
endmodule
